// [shared/bioprt_pkg.sv]
// shared constants for the bus attached port pair
package bioprt_pkg;
    localparam int unsigned PORT_W    = 8;         // pins per port
    localparam int unsigned REG_SEL_W = 2;         // register select width
    // register select codes, taken from the two low address lines
    localparam logic [1:0] SEL_DATA_A = 2'h0;      // port a data latch
    localparam logic [1:0] SEL_DIR_A  = 2'h1;      // port a direction
    localparam logic [1:0] SEL_DATA_B = 2'h2;      // port b data latch
    localparam logic [1:0] SEL_DIR_B  = 2'h3;      // port b direction
    localparam logic [7:0] RST_REG    = 8'h00;     // reset value of all port registers
    localparam int unsigned IRQ_BIT   = 7;         // port b bit shared with interrupt
    localparam int unsigned SYNC_LEN  = 3;         // synchroniser stages for pins
    // bus cycle state machine, gray coded but for the done to idle step
    typedef enum logic [1:0] {
        BIOPRT_IDLE = 2'b00,   // phase two low
        BIOPRT_HIGH = 2'b01,   // phase two high, cycle in progress
        BIOPRT_DONE = 2'b11    // falling edge seen, commit cycle
    } bioprt_state_e;
endpackage : bioprt_pkg

// [rtl/bioprt_top.sv]
// bus attached pair of 8 bit bidirectional ports with shared interrupt pin
`timescale 1ns/1ps

module bioprt_top #(
    parameter int unsigned PORT_W = bioprt_pkg::PORT_W    // pins per port
) (
    input  wire logic              CLK_SYS,               // system clock, 100 MHz
    input  wire logic              RST,                   // async reset, active high
    input  wire logic              RESET_IN_N,            // device reset pin, active low
    input  wire logic              PHI2,                  // host phase two clock pin
    input  wire logic              RW,                    // high read, low write
    input  wire logic              IO_TIMER_SEL,          // port/timer chip select, high
    input  wire logic              PORT_TIMER_SELECT_LINE,// high ports, low timer
    input  wire logic              REG_SELECT_HI,         // register select msb
    input  wire logic              REG_SELECT_LO,         // register select lsb
    input  wire logic              IRQ_ENABLE_LINE,       // interrupt enable on timer access
    input  wire logic              TIMER_IRQ_FLAG,        // pending timer interrupt level
    input  wire logic [7:0]        HOST_DATA_LINES_I,     // host data bus in
    output logic      [7:0]        HOST_DATA_LINES_O,     // host data bus out
    output logic                   HOST_DATA_LINES_OE,    // high while driving host bus
    input  wire logic [PORT_W-1:0] PORT_A_PINS_I,         // port a pin levels
    output logic      [PORT_W-1:0] PORT_A_PINS_O,         // port a drive value
    output logic      [PORT_W-1:0] PORT_A_PINS_OE,        // port a strong drive enable
    input  wire logic [PORT_W-1:0] PORT_B_PINS_I,         // port b pin levels
    output logic      [PORT_W-1:0] PORT_B_PINS_O,         // port b drive value
    output logic      [PORT_W-1:0] PORT_B_PINS_OE,        // port b strong drive enable
    output logic                   IRQ_ENABLED            // interrupt capability status
);

    // pin synchronisers: three stages, change accepted once stages two and three agree
    logic [2:0] ctl_s1_q, ctl_s2_q, ctl_s3_q;             // reset_n, phi2, rw
    logic [2:0] ctl_f_q, ctl_f_d;                         // filtered control levels
    logic [PORT_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_f_q, pa_f_d;
    logic [PORT_W-1:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_f_q, pb_f_d;
    logic [4:0]        adr_s1_q, adr_s2_q, adr_s3_q;      // enable, select hi/lo, ports, cs
    logic [4:0]        adr_f_q, adr_f_d;                  // filtered address levels
    logic [7:0]        wd_s1_q, wd_s2_q, wd_s3_q;         // host write data stages
    logic [7:0]        wd_f_q, wd_f_d;                    // filtered host write data

    // synchroniser chain registers only
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctl_s1_q <= 3'h1;  // reset pin idles high, phi2 low, rw low
            ctl_s2_q <= 3'h1;
            ctl_s3_q <= 3'h1;
            pa_s1_q  <= '1;
            pa_s2_q  <= '1;
            pa_s3_q  <= '1;
            pb_s1_q  <= '1;
            pb_s2_q  <= '1;
            pb_s3_q  <= '1;
            adr_s1_q <= '0;    // host bus idles unselected
            adr_s2_q <= '0;
            adr_s3_q <= '0;
            wd_s1_q  <= '0;
            wd_s2_q  <= '0;
            wd_s3_q  <= '0;
        end else begin
            ctl_s1_q <= {RW, PHI2, RESET_IN_N};
            ctl_s2_q <= ctl_s1_q;
            ctl_s3_q <= ctl_s2_q;
            pa_s1_q  <= PORT_A_PINS_I;
            pa_s2_q  <= pa_s1_q;
            pa_s3_q  <= pa_s2_q;
            pb_s1_q  <= PORT_B_PINS_I;
            pb_s2_q  <= pb_s1_q;
            pb_s3_q  <= pb_s2_q;
            adr_s1_q <= {IRQ_ENABLE_LINE, REG_SELECT_HI, REG_SELECT_LO,
                         PORT_TIMER_SELECT_LINE, IO_TIMER_SEL};
            adr_s2_q <= adr_s1_q;
            adr_s3_q <= adr_s2_q;
            wd_s1_q  <= HOST_DATA_LINES_I;
            wd_s2_q  <= wd_s1_q;
            wd_s3_q  <= wd_s2_q;
        end
    end

    // filter: a bit follows only when the last two stages agree, rejecting glitches
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ctl_f_d[i] = (ctl_s2_q[i] == ctl_s3_q[i]) ? ctl_s3_q[i] : ctl_f_q[i];
        end
        for (int i = 0; i < PORT_W; i++) begin
            pa_f_d[i] = (pa_s2_q[i] == pa_s3_q[i]) ? pa_s3_q[i] : pa_f_q[i];
            pb_f_d[i] = (pb_s2_q[i] == pb_s3_q[i]) ? pb_s3_q[i] : pb_f_q[i];
        end
        for (int i = 0; i < 5; i++) begin
            adr_f_d[i] = (adr_s2_q[i] == adr_s3_q[i]) ? adr_s3_q[i] : adr_f_q[i];
        end
        for (int i = 0; i < 8; i++) begin
            wd_f_d[i] = (wd_s2_q[i] == wd_s3_q[i]) ? wd_s3_q[i] : wd_f_q[i];
        end
    end

    // filtered level registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctl_f_q <= 3'h1;
            pa_f_q  <= '1;
            pb_f_q  <= '1;
            adr_f_q <= '0;
            wd_f_q  <= '0;
        end else begin
            ctl_f_q <= ctl_f_d;
            pa_f_q  <= pa_f_d;
            pb_f_q  <= pb_f_d;
            adr_f_q <= adr_f_d;
            wd_f_q  <= wd_f_d;
        end
    end

    logic dev_rst_n;   // filtered device reset, active low
    logic phi2_f;      // filtered phase two
    logic rw_f;        // filtered direction line
    assign dev_rst_n = ctl_f_q[0];
    assign phi2_f    = ctl_f_q[1];
    assign rw_f      = ctl_f_q[2];

    // address lines share the latency of phase two, so both agree at the capture edge
    logic       cs_f;      // filtered port/timer select
    logic       pts_f;     // filtered ports versus timer line
    logic [1:0] rsel_f;    // filtered register select
    logic       ien_f;     // filtered interrupt enable line
    assign cs_f   = adr_f_q[0];
    assign pts_f  = adr_f_q[1];
    assign rsel_f = adr_f_q[3:2];
    assign ien_f  = adr_f_q[4];

    // address and select come from the host with setup before phase two rises;
    // they are captured at the rising edge seen here, by which time they have settled
    logic [1:0]           sel_q, sel_d;        // captured register select
    logic                 io_q, io_d;          // captured port access
    logic                 tmr_q, tmr_d;        // captured timer access
    logic                 irqen_line_q, irqen_line_d;
    logic                 rd_q, rd_d;          // captured read direction
    bioprt_pkg::bioprt_state_e st_q, st_d;     // bus cycle state

    // port registers
    logic [PORT_W-1:0] dir_a_q, dir_a_d, dat_a_q, dat_a_d;
    logic [PORT_W-1:0] dir_b_q, dir_b_d, dat_b_q, dat_b_d;
    logic              irq_en_q, irq_en_d;

    // bus cycle tracking and register updates
    always_comb begin
        st_d         = st_q;
        sel_d        = sel_q;
        io_d         = io_q;
        tmr_d        = tmr_q;
        irqen_line_d = irqen_line_q;
        rd_d         = rd_q;
        dir_a_d      = dir_a_q;
        dat_a_d      = dat_a_q;
        dir_b_d      = dir_b_q;
        dat_b_d      = dat_b_q;
        irq_en_d     = irq_en_q;
        case (st_q)
            bioprt_pkg::BIOPRT_IDLE: begin
                if (phi2_f) begin
                    // capture the cycle attributes at the rising edge
                    st_d         = bioprt_pkg::BIOPRT_HIGH;
                    sel_d        = rsel_f;
                    io_d         = cs_f & pts_f;
                    tmr_d        = cs_f & ~pts_f;
                    irqen_line_d = ien_f;
                    rd_d         = rw_f;
                end
            end
            bioprt_pkg::BIOPRT_HIGH: begin
                // write commits on the falling edge of phase two
                if (!phi2_f) begin
                    st_d = bioprt_pkg::BIOPRT_DONE;
                end
            end
            bioprt_pkg::BIOPRT_DONE: begin
                st_d = bioprt_pkg::BIOPRT_IDLE;
                if (io_q && !rd_q) begin
                    // only a write reaches the latches; reads leave them alone
                    case (sel_q)
                        bioprt_pkg::SEL_DATA_A: dat_a_d = wd_f_q;
                        bioprt_pkg::SEL_DIR_A:  dir_a_d = wd_f_q;
                        bioprt_pkg::SEL_DATA_B: dat_b_d = wd_f_q;
                        bioprt_pkg::SEL_DIR_B:  dir_b_d = wd_f_q;
                        default:                dat_a_d = dat_a_q;
                    endcase
                end
                // any timer access, read or write, updates interrupt enable
                if (tmr_q) begin
                    irq_en_d = irqen_line_q;
                end
            end
            default: st_d = bioprt_pkg::BIOPRT_IDLE;
        endcase
        // device reset pin overrides everything but the captured register select and enable line
        if (!dev_rst_n) begin
            st_d     = bioprt_pkg::BIOPRT_IDLE;
            rd_d     = 1'b0;
            io_d     = 1'b0;
            tmr_d    = 1'b0;
            dir_a_d  = bioprt_pkg::RST_REG;
            dat_a_d  = bioprt_pkg::RST_REG;
            dir_b_d  = bioprt_pkg::RST_REG;
            dat_b_d  = bioprt_pkg::RST_REG;
            irq_en_d = 1'b0;
        end
    end

    // cycle and port register state
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_q         <= bioprt_pkg::BIOPRT_IDLE;
            sel_q        <= 2'h0;
            io_q         <= 1'b0;
            tmr_q        <= 1'b0;
            irqen_line_q <= 1'b0;
            rd_q         <= 1'b0;
            dir_a_q      <= bioprt_pkg::RST_REG;
            dat_a_q      <= bioprt_pkg::RST_REG;
            dir_b_q      <= bioprt_pkg::RST_REG;
            dat_b_q      <= bioprt_pkg::RST_REG;
            irq_en_q     <= 1'b0;
        end else begin
            st_q         <= st_d;
            sel_q        <= sel_d;
            io_q         <= io_d;
            tmr_q        <= tmr_d;
            irqen_line_q <= irqen_line_d;
            rd_q         <= rd_d;
            dir_a_q      <= dir_a_d;
            dat_a_q      <= dat_a_d;
            dir_b_q      <= dir_b_d;
            dat_b_q      <= dat_b_d;
            irq_en_q     <= irq_en_d;
        end
    end

    // output stage next values
    logic [7:0]        hd_o_d, hd_o_q;
    logic              hd_oe_d, hd_oe_q;
    logic [PORT_W-1:0] pa_o_d, pa_o_q, pa_oe_d, pa_oe_q;
    logic [PORT_W-1:0] pb_o_d, pb_o_q, pb_oe_d, pb_oe_q;
    logic [PORT_W-1:0] rd_a, rd_b;       // read-back views per pin

    // per pin drive and read-back; one loop serves every bit of both ports
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            // output pins read the latch, input pins read the pin
            rd_a[i]    = dir_a_q[i] ? dat_a_q[i] : pa_f_q[i];
            rd_b[i]    = dir_b_q[i] ? dat_b_q[i] : pb_f_q[i];
            // input pins float at one: drive value one, strong drive off, pullup holds
            pa_o_d[i]  = dir_a_q[i] ? dat_a_q[i] : 1'b1;
            pa_oe_d[i] = dir_a_q[i];
            pb_o_d[i]  = dir_b_q[i] ? dat_b_q[i] : 1'b1;
            pb_oe_d[i] = dir_b_q[i];
        end
        // pending interrupt pulls the shared pin low while enabled; the direction bit
        // should be zero then, otherwise the interrupt pull overrides the latch value on the pin
        if (irq_en_q && TIMER_IRQ_FLAG) begin
            pb_o_d[bioprt_pkg::IRQ_BIT]  = 1'b0;
            pb_oe_d[bioprt_pkg::IRQ_BIT] = 1'b1;
        end
        // read data only while phase two is high in an addressed port read
        hd_oe_d = dev_rst_n && phi2_f && (st_q == bioprt_pkg::BIOPRT_HIGH)
                  && io_q && rd_q;
        case (sel_q)
            bioprt_pkg::SEL_DATA_A: hd_o_d = rd_a;
            bioprt_pkg::SEL_DIR_A:  hd_o_d = dir_a_q;
            bioprt_pkg::SEL_DATA_B: hd_o_d = rd_b;
            bioprt_pkg::SEL_DIR_B:  hd_o_d = dir_b_q;
            default:                hd_o_d = 8'h00;
        endcase
        if (!hd_oe_d) begin
            hd_o_d = 8'h00;
        end
    end

    // output registers so every top output comes from a flip-flop
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            hd_o_q  <= 8'h00;
            hd_oe_q <= 1'b0;
            pa_o_q  <= '1;
            pa_oe_q <= '0;
            pb_o_q  <= '1;
            pb_oe_q <= '0;
        end else begin
            hd_o_q  <= hd_o_d;
            hd_oe_q <= hd_oe_d;
            pa_o_q  <= pa_o_d;
            pa_oe_q <= pa_oe_d;
            pb_o_q  <= pb_o_d;
            pb_oe_q <= pb_oe_d;
        end
    end

    assign HOST_DATA_LINES_O  = hd_o_q;
    assign HOST_DATA_LINES_OE = hd_oe_q;
    assign PORT_A_PINS_O      = pa_o_q;
    assign PORT_A_PINS_OE     = pa_oe_q;
    assign PORT_B_PINS_O      = pb_o_q;
    assign PORT_B_PINS_OE     = pb_oe_q;
    assign IRQ_ENABLED        = irq_en_q;

endmodule // bioprt_top

// [test/bioprt_properties.sv]
// assertion checker for the bus attached port pair
`timescale 1ns/1ps
module bioprt_checker #(
    parameter int unsigned PORT_W = 8                  // pins per port
) (
    input wire logic              CLK_SYS,                // system clock
    input wire logic              RST,                    // async reset
    input wire logic              RESET_IN_N,             // device reset pin
    input wire logic              PHI2,                   // phase two clock
    input wire logic              RW,                     // high read
    input wire logic              IO_TIMER_SEL,           // port/timer select
    input wire logic              PORT_TIMER_SELECT_LINE, // high ports
    input wire logic              IRQ_ENABLE_LINE,        // interrupt enable line
    input wire logic              TIMER_IRQ_FLAG,         // pending timer interrupt
    input wire logic [7:0]        HOST_DATA_LINES_O,      // read data
    input wire logic              HOST_DATA_LINES_OE,     // host bus drive
    input wire logic [PORT_W-1:0] PORT_A_PINS_O,          // port a drive
    input wire logic [PORT_W-1:0] PORT_A_PINS_OE,         // port a enable
    input wire logic [PORT_W-1:0] PORT_B_PINS_O,          // port b drive
    input wire logic [PORT_W-1:0] PORT_B_PINS_OE,         // port b enable
    input wire logic              IRQ_ENABLED             // interrupt state
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // device reset held long enough to pass the pin synchroniser
    sequence s_devrst_held;
        !RESET_IN_N [*8];
    endsequence
    // enabled interrupt pending for a few clocks
    sequence s_irq_on;
        (IRQ_ENABLED && TIMER_IRQ_FLAG) [*4];
    endsequence
    AST_DEVRST_CLR: assert property (s_devrst_held |-> !HOST_DATA_LINES_OE && !IRQ_ENABLED
        && PORT_A_PINS_OE == '0 && PORT_B_PINS_OE == '0) else $error("reset did not clear");
    AST_IRQ_DEVRST: assert property ($fell(RESET_IN_N) |-> ##[1:8] !IRQ_ENABLED)
        else $error("reset left interrupt enabled");
    AST_OE_CAUSE: assert property ($rose(HOST_DATA_LINES_OE) |-> PHI2 && RW
        && IO_TIMER_SEL && PORT_TIMER_SELECT_LINE) else $error("bus driven outside read");
    AST_OE_OFF: assert property (!PHI2 [*8] |-> !HOST_DATA_LINES_OE)
        else $error("bus driven while idle");
    AST_OE_HOLD: assert property ($rose(HOST_DATA_LINES_OE) |=>
        (HOST_DATA_LINES_OE && $stable(HOST_DATA_LINES_O)) [*3]) else $error("read data moved");
    AST_PULLUP: assert property (&(PORT_A_PINS_O | PORT_A_PINS_OE)
        && &(PORT_B_PINS_O | PORT_B_PINS_OE)) else $error("input pin not held high");
    AST_PIN_WR: assert property ($changed({PORT_A_PINS_O, PORT_A_PINS_OE}) |->
        !RESET_IN_N || (!PHI2 && !RW && IO_TIMER_SEL)) else $error("pin moved without write");
    AST_IRQ_PULL: assert property (s_irq_on |-> PORT_B_PINS_OE[7] && !PORT_B_PINS_O[7])
        else $error("shared pin not pulled low");
    AST_IRQ_WR: assert property ($rose(IRQ_ENABLED) |-> !PHI2 && IO_TIMER_SEL
        && !PORT_TIMER_SELECT_LINE && IRQ_ENABLE_LINE) else $error("interrupt enabled unasked");
endmodule // bioprt_checker

bind bioprt_top bioprt_checker #(.PORT_W(PORT_W)) chk_u (.CLK_SYS, .RST, .RESET_IN_N,
    .PHI2, .RW, .IO_TIMER_SEL, .PORT_TIMER_SELECT_LINE, .IRQ_ENABLE_LINE, .TIMER_IRQ_FLAG,
    .HOST_DATA_LINES_O, .HOST_DATA_LINES_OE, .PORT_A_PINS_O, .PORT_A_PINS_OE,
    .PORT_B_PINS_O, .PORT_B_PINS_OE, .IRQ_ENABLED);

// [test/bioprt_host_model.sv]
// host processor model running phase two bus cycles
`timescale 1ns/1ps
module bioprt_host_model (
    input  wire logic       clk,    // system clock
    input  wire logic [7:0] rdata,  // read data from the block
    input  wire logic       roe,    // block drives the host bus
    output logic            phi2,   // phase two clock
    output logic            rw,     // high read, low write
    output logic            cs,     // port/timer select
    output logic            pts,    // high ports, low timer
    output logic [1:0]      sel,    // register select
    output logic            ien,    // interrupt enable line
    output logic [7:0]      wdata   // write data
);
    // idle bus: phase two low, nothing selected
    initial begin
        phi2 = 1'b0;
        rw = 1'b1;
        cs = 1'b0;
        pts = 1'b0;
        sel = 2'h0;
        ien = 1'b0;
        wdata = 8'h00;
    end
    // eight clocks high, eight low; address and write data held over the whole cycle so the
    // commit, which lands after phase two falls, still sees the data
    task automatic cycle(input logic r, input logic c, input logic p, input logic [1:0] s,
                         input logic e, input logic [7:0] d, output logic [7:0] q);
        q = 8'hzz;
        @(posedge clk);
        rw <= r;
        cs <= c;
        pts <= p;
        sel <= s;
        ien <= e;
        wdata <= r ? ~wdata : d; // no stale data while reading
        phi2 <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            if (roe === 1'b1) q = rdata; // taken while phase two high
        end
        phi2 <= 1'b0;
        repeat (8) @(posedge clk);
        cs <= 1'b0; // release, bus data turned over
        wdata <= ~wdata;
    endtask
endmodule // bioprt_host_model

// [test/testbench.sv]
// self-checking bench for the bus attached port pair
`timescale 1ns/1ps
module testbench;
    logic       clk_sys, rst, reset_in_n, timer_irq_flag, phi2, rw, cs, pts, ien, roe, irq_en;
    logic [1:0] sel;
    logic [7:0] wdata, rdata, ext_a, ext_b, a_o, a_oe, b_o, b_oe, a_i, b_i;
    int         failures, n_tests;
    // pin level: own drive where enabled, peripheral elsewhere
    assign a_i = (a_o & a_oe) | (ext_a & ~a_oe);
    assign b_i = (b_o & b_oe) | (ext_b & ~b_oe);
    bioprt_top dut_u (.CLK_SYS(clk_sys), .RST(rst), .RESET_IN_N(reset_in_n), .PHI2(phi2),
        .RW(rw), .IO_TIMER_SEL(cs), .PORT_TIMER_SELECT_LINE(pts), .REG_SELECT_HI(sel[1]),
        .REG_SELECT_LO(sel[0]), .IRQ_ENABLE_LINE(ien), .TIMER_IRQ_FLAG(timer_irq_flag),
        .HOST_DATA_LINES_I(wdata), .HOST_DATA_LINES_O(rdata), .HOST_DATA_LINES_OE(roe),
        .PORT_A_PINS_I(a_i), .PORT_A_PINS_O(a_o), .PORT_A_PINS_OE(a_oe), .PORT_B_PINS_I(b_i),
        .PORT_B_PINS_O(b_o), .PORT_B_PINS_OE(b_oe), .IRQ_ENABLED(irq_en));
    bioprt_host_model host_u (.clk(clk_sys), .rdata(rdata), .roe(roe), .phi2(phi2), .rw(rw),
        .cs(cs), .pts(pts), .sel(sel), .ien(ien), .wdata(wdata));
    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // byte compare, unknown and floating bits must match exactly
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // counts, verdict, end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // register values straight after reset
    task automatic t_reset();
        check8("pins drive", 8'hff, a_o & b_o);
        check8("pins enable", 8'h00, a_oe | b_oe);
        check8("irq state", 8'h00, {7'h0, irq_en});
    endtask
    // each port: mixed directions, read back, latch untouched by reads
    task automatic t_ports();
        logic [7:0] q;
        for (int p = 0; p < 2; p++) begin
            host_u.cycle(1'b0, 1'b1, 1'b1, p ? 2'h3 : 2'h1, 1'b0, 8'h70, q);
            host_u.cycle(1'b0, 1'b1, 1'b1, p ? 2'h2 : 2'h0, 1'b0, 8'h5a, q);
            repeat (10) @(posedge clk_sys);
            check8("pin enable", 8'h70, p ? b_oe : a_oe);
            check8("pin drive", 8'hdf, p ? b_o : a_o);
            host_u.cycle(1'b1, 1'b1, 1'b1, p ? 2'h2 : 2'h0, 1'b0, 8'h00, q);
            check8("port read", 8'h50 | ((p ? ext_b : ext_a) & 8'h8f), q);
            host_u.cycle(1'b1, 1'b1, 1'b1, p ? 2'h3 : 2'h1, 1'b0, 8'h00, q);
            check8("dir read", 8'h70, q);
            check8("latch kept", 8'hdf, p ? b_o : a_o);
        end
    endtask
    // unselected and timer accesses leave ports and bus alone
    task automatic t_refused();
        logic [7:0] q;
        host_u.cycle(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 8'h00, q);
        host_u.cycle(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 8'h00, q);
        repeat (10) @(posedge clk_sys);
        check8("latch kept", 8'hdf, a_o);
        host_u.cycle(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 8'h00, q);
        check8("bus idle", 8'hzz, q);
        check8("irq state", 8'h00, {7'h0, irq_en});
    endtask
    // enable line on timer accesses, shared pin pulled low while pending
    task automatic t_irq();
        logic [7:0] q;
        host_u.cycle(1'b1, 1'b1, 1'b0, 2'h0, 1'b1, 8'h00, q);
        check8("irq state", 8'h01, {7'h0, irq_en});
        timer_irq_flag <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check8("shared pin", 8'h02, {6'h0, b_oe[7], b_o[7]});
        host_u.cycle(1'b0, 1'b1, 1'b0, 2'h1, 1'b0, 8'h00, q);
        check8("irq state", 8'h00, {7'h0, irq_en});
        check8("shared pin", 8'h01, {6'h0, b_oe[7], b_o[7]});
        host_u.cycle(1'b0, 1'b1, 1'b0, 2'h2, 1'b1, 8'h00, q);
        check8("irq state", 8'h01, {7'h0, irq_en});
    endtask
    // device reset pin during a read with the interrupt pending
    task automatic t_devres();
        logic [7:0] q;
        reset_in_n <= 1'b0;
        host_u.cycle(1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 8'h00, q);
        check8("bus in reset", 8'hzz, q);
        check8("pins enable", 8'h00, a_oe | b_oe);
        check8("pins drive", 8'hff, a_o & b_o);
        check8("irq state", 8'h00, {7'h0, irq_en});
        reset_in_n <= 1'b1;
        timer_irq_flag <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        reset_in_n = 1'b1;
        timer_irq_flag = 1'b0;
        ext_a = 8'h33;
        ext_b = 8'hc3;
        failures = 0;
        n_tests = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        t_reset();
        t_ports();
        t_refused();
        t_irq();
        t_devres();
        finish_test();
    end
    // hang guard, about thirty times the expected run
    initial begin
        #100us;
        failures++;
        finish_test();
    end
endmodule // testbench
